// *** include/link_cap_ctrl_pkg.sv ***
// constants for the link capability, control and status register bank
package link_cap_ctrl_pkg;

  // ****************************************
  // configuration space offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] OFF_LINK_CAPABILITIES = 12'h07c;
  localparam logic [11:0] OFF_LINK_CONTROL = 12'h080;
  localparam logic [11:0] OFF_LINK_STATUS = 12'h082;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // ****************************************
  // link capabilities fields
  // ****************************************
  localparam int CAP_PORT_NUM_LSB = 24;
  localparam logic [7:0] CAP_PORT_NUM = 8'h00;
  localparam int CAP_CLOCK_POWER_MGMT_SUPPORTED_BIT = 18;
  localparam logic CAP_CLOCK_POWER_MGMT_SUPPORTED = 1'b1;
  localparam int CAP_L1_EXIT_LSB = 15;
  localparam int CAP_L0S_EXIT_LSB = 12;
  localparam int CAP_ASPM_SUP_LSB = 10;
  localparam logic [1:0] CAP_ASPM_SUP = 2'h3;
  localparam int CAP_MAX_WIDTH_LSB = 4;
  localparam logic [5:0] CAP_MAX_WIDTH = 6'h01;
  localparam int CAP_MAX_SPEED_LSB = 0;
  localparam logic [3:0] CAP_MAX_SPEED = 4'h2;
  localparam int LAT_W = 3;

  // ****************************************
  // link control fields
  // ****************************************
  localparam int CTL_CLOCK_PM_EN_BIT = 8;
  localparam int CTL_EXT_SYNCH_BIT = 7;
  localparam int CTL_COMMON_CLK_BIT = 6;
  localparam int CTL_RETRAIN_BIT = 5;
  localparam int CTL_LINK_OFF_BIT = 4;
  localparam int CTL_RCB_BIT = 3;
  localparam int CTL_ASPM_LSB = 0;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] CTL_WR_MASK = 16'h01cb;

  // ****************************************
  // link status fields
  // ****************************************
  localparam int STS_SLOT_CLK_BIT = 12;
  localparam logic STS_SLOT_CLK = 1'b1;
  localparam int STS_NEG_WIDTH_LSB = 4;
  localparam logic [5:0] STS_NEG_WIDTH = 6'h01;
  localparam int STS_SPEED_LSB = 0;

  // aspm control encodings
  typedef enum logic [1:0] {
    ASPM_OFF = 2'b00,
    ASPM_L0S = 2'b01,
    ASPM_L1 = 2'b10,
    ASPM_BOTH = 2'b11
  } aspm_mode_t;

endpackage

// *** include/exit_latency_if.sv ***
// carrier between the register bank and its exit latency selector
`timescale 1ns/1ns
interface exit_latency_if;
  logic common_clock;
  logic [2:0] l1_async;
  logic [2:0] l1_shared;
  logic [2:0] l0s_async;
  logic [2:0] l0s_shared;
  logic [2:0] l1_exit_time;
  logic [2:0] l0s_exit_time;

  modport bank (
    output common_clock, l1_async, l1_shared, l0s_async, l0s_shared,
    input l1_exit_time, l0s_exit_time
  );
  modport sel (
    input common_clock, l1_async, l1_shared, l0s_async, l0s_shared,
    output l1_exit_time, l0s_exit_time
  );
endinterface

// *** src/exit_latency_select.sv ***
// picks the reported exit latencies by the common clock selection
`timescale 1ns/1ns
module exit_latency_select (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  exit_latency_if.sel lat
);
  import link_cap_ctrl_pkg::*;

  logic [LAT_W-1:0] l1_ff;
  logic [LAT_W-1:0] l0s_ff;
  logic [LAT_W-1:0] nxt_l1;
  logic [LAT_W-1:0] nxt_l0s;

  // shared clock values when both ends run off one reference
  always_comb begin
    nxt_l1 = lat.common_clock ? lat.l1_shared : lat.l1_async;
    nxt_l0s = lat.common_clock ? lat.l0s_shared : lat.l0s_async;
  end

  // registered so the read path sees a clean flop, one cycle behind
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      l1_ff <= '0;
      l0s_ff <= '0;
    end else begin
      l1_ff <= nxt_l1;
      l0s_ff <= nxt_l0s;
    end
  end

  assign lat.l1_exit_time = l1_ff;
  assign lat.l0s_exit_time = l0s_ff;
endmodule

// *** src/link_cap_ctrl_regs.sv ***
// link capability, control and status register bank in config space
`timescale 1ns/1ns
module link_cap_ctrl_regs (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // configuration access port
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [link_cap_ctrl_pkg::ADDR_W-1:0] i_cfg_addr,
  input wire logic [link_cap_ctrl_pkg::BE_W-1:0] i_cfg_be,
  input wire logic [link_cap_ctrl_pkg::DATA_W-1:0] i_cfg_wdata,
  output logic [link_cap_ctrl_pkg::DATA_W-1:0] o_cfg_rdata,
  output logic o_cfg_rd_valid,
  output logic o_cfg_wr_done,
  // latency values held by the general control register
  input wire logic [link_cap_ctrl_pkg::LAT_W-1:0] i_l1_exit_time_async,
  input wire logic [link_cap_ctrl_pkg::LAT_W-1:0] i_l1_exit_time_shared_clk,
  input wire logic [link_cap_ctrl_pkg::LAT_W-1:0] i_l0s_exit_time_async,
  input wire logic [link_cap_ctrl_pkg::LAT_W-1:0] i_l0s_exit_time_shared_clk,
  // live speed from the link layer
  input wire logic [3:0] i_current_link_speed,
  // control exported to the link power-state logic
  output logic [1:0] o_aspm_control,
  output logic o_l0s_entry_enable,
  output logic o_l1_entry_enable,
  output logic o_clock_pm_enable,
  output logic o_extended_synch,
  output logic o_common_clock_select,
  output logic o_read_completion_boundary
);
  import link_cap_ctrl_pkg::*;

  // ****************************************
  // decode helpers
  // ****************************************

  // dword match on the word address, byte offset bits ignored
  function automatic logic dword_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] base);
    dword_hit = (addr[ADDR_W-1:2] == base[ADDR_W-1:2]);
  endfunction

  // expand byte enables into a bit mask over the whole dword
  function automatic logic [DATA_W-1:0] lane_mask(input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < BE_W; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    lane_mask = m;
  endfunction

  // ****************************************
  // storage for the link control word
  // ****************************************
  logic [15:0] ctl_ff;
  logic [15:0] nxt_ctl;
  logic ctl_wr_hit;
  logic [15:0] ctl_lane;
  logic [DATA_W-1:0] be_lanes;

  // control sits in the low half, so only lanes 0 and 1 matter here
  assign ctl_wr_hit = i_cfg_wr && dword_hit(i_cfg_addr, OFF_LINK_CONTROL);
  assign be_lanes = lane_mask(i_cfg_be);
  assign ctl_lane = be_lanes[15:0];

  // only the writable bits take new data; retrain, link off and reserved
  // bits are outside the mask so they can never be set
  always_comb begin
    nxt_ctl = ctl_ff;
    if (ctl_wr_hit) begin
      // clock pm enable, ext synch, common clock, rcb, aspm mode
      nxt_ctl = (ctl_ff & ~(CTL_WR_MASK & ctl_lane))
              | (i_cfg_wdata[15:0] & CTL_WR_MASK & ctl_lane);
    end
    nxt_ctl = nxt_ctl & CTL_WR_MASK;
  end

  // control word, cleared on reset
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctl_ff <= CTL_RESET;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  // ****************************************
  // exit latency selection
  // ****************************************
  exit_latency_if lat_if ();

  // host picks the common clock bit; the selector follows it
  assign lat_if.common_clock = ctl_ff[CTL_COMMON_CLK_BIT];
  assign lat_if.l1_async = i_l1_exit_time_async;
  assign lat_if.l1_shared = i_l1_exit_time_shared_clk;
  assign lat_if.l0s_async = i_l0s_exit_time_async;
  assign lat_if.l0s_shared = i_l0s_exit_time_shared_clk;

  exit_latency_select u_lat_sel (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .lat(lat_if.sel)
  );

  // ****************************************
  // read-side words
  // ****************************************
  logic [DATA_W-1:0] cap_word;
  logic [15:0] sts_word;

  // capability word, constants plus the mirrored latencies
  always_comb begin
    cap_word = '0; // reserved 23:19 stay zero
    cap_word[CAP_PORT_NUM_LSB +: 8] = CAP_PORT_NUM;
    cap_word[CAP_CLOCK_POWER_MGMT_SUPPORTED_BIT] = CAP_CLOCK_POWER_MGMT_SUPPORTED;
    cap_word[CAP_L1_EXIT_LSB +: LAT_W] = lat_if.l1_exit_time;
    cap_word[CAP_L0S_EXIT_LSB +: LAT_W] = lat_if.l0s_exit_time;
    cap_word[CAP_ASPM_SUP_LSB +: 2] = CAP_ASPM_SUP;
    cap_word[CAP_MAX_WIDTH_LSB +: 6] = CAP_MAX_WIDTH;
    cap_word[CAP_MAX_SPEED_LSB +: 4] = CAP_MAX_SPEED;
  end

  // status word, speed is live rather than stored
  always_comb begin
    sts_word = '0;
    sts_word[STS_SLOT_CLK_BIT] = STS_SLOT_CLK;
    sts_word[STS_NEG_WIDTH_LSB +: 6] = STS_NEG_WIDTH;
    sts_word[STS_SPEED_LSB +: 4] = i_current_link_speed;
  end

  // ****************************************
  // configuration read mux
  // ****************************************
  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] rdata_ff;
  logic rd_valid_ff;
  logic wr_done_ff;

  // control and status share one dword; unmapped dwords read zero
  always_comb begin
    nxt_rdata = '0;
    if (dword_hit(i_cfg_addr, OFF_LINK_CAPABILITIES)) begin
      nxt_rdata = cap_word;
    end else if (dword_hit(i_cfg_addr, OFF_LINK_CONTROL)) begin
      nxt_rdata = {sts_word, ctl_ff};
    end
    // byte enables trim the answer so unrequested lanes read zero
    nxt_rdata = nxt_rdata & lane_mask(i_cfg_be);
  end

  // read data held until the next read replaces it
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_ff <= '0;
    end else if (i_cfg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // one-cycle completion strobes
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rd_valid_ff <= 1'b0;
      wr_done_ff <= 1'b0;
    end else begin
      rd_valid_ff <= i_cfg_rd;
      wr_done_ff <= i_cfg_wr;
    end
  end

  assign o_cfg_rdata = rdata_ff;
  assign o_cfg_rd_valid = rd_valid_ff;
  assign o_cfg_wr_done = wr_done_ff;

  // ****************************************
  // exported power management control
  // ****************************************
  aspm_mode_t aspm_mode;

  // power-state logic may only enter a state software has enabled
  assign aspm_mode = aspm_mode_t'(ctl_ff[CTL_ASPM_LSB +: 2]);
  assign o_aspm_control = ctl_ff[CTL_ASPM_LSB +: 2];
  assign o_l0s_entry_enable = (aspm_mode == ASPM_L0S) || (aspm_mode == ASPM_BOTH);
  assign o_l1_entry_enable = (aspm_mode == ASPM_L1) || (aspm_mode == ASPM_BOTH);
  assign o_clock_pm_enable = ctl_ff[CTL_CLOCK_PM_EN_BIT];
  assign o_extended_synch = ctl_ff[CTL_EXT_SYNCH_BIT];
  assign o_common_clock_select = ctl_ff[CTL_COMMON_CLK_BIT];
  assign o_read_completion_boundary = ctl_ff[CTL_RCB_BIT];

endmodule

// *** verif/link_cap_ctrl_regs_asserts.sv ***
// port checker for the link register bank
`timescale 1ns/1ns
module link_cap_ctrl_regs_asserts
  import link_cap_ctrl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [11:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic o_cfg_rd_valid,
  input wire logic o_cfg_wr_done,
  input wire logic [2:0] i_l1_exit_time_async,
  input wire logic [2:0] i_l1_exit_time_shared_clk,
  input wire logic [2:0] i_l0s_exit_time_async,
  input wire logic [2:0] i_l0s_exit_time_shared_clk,
  input wire logic [3:0] i_current_link_speed,
  input wire logic [1:0] o_aspm_control,
  input wire logic o_l0s_entry_enable,
  input wire logic o_l1_entry_enable,
  input wire logic o_clock_pm_enable,
  input wire logic o_extended_synch,
  input wire logic o_common_clock_select,
  input wire logic o_read_completion_boundary
);
  // ****************
  // views and steps
  // ****************
  logic [15:0] ctl_view;
  logic [5:0] lat_sel;
  // control word as software should see it, from the exported bits
  assign ctl_view = {7'h0, o_clock_pm_enable, o_extended_synch, o_common_clock_select,
    2'b0, o_read_completion_boundary, 1'b0, o_aspm_control};
  assign lat_sel = o_common_clock_select ?
    {i_l1_exit_time_shared_clk, i_l0s_exit_time_shared_clk} :
    {i_l1_exit_time_async, i_l0s_exit_time_async};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_rd_cap;
    i_cfg_rd && i_cfg_addr[11:2] == OFF_LINK_CAPABILITIES[11:2] && i_cfg_be == 4'hf;
  endsequence
  sequence s_rd_ctl;
    i_cfg_rd && i_cfg_addr[11:2] == OFF_LINK_CONTROL[11:2] && i_cfg_be == 4'hf;
  endsequence
  sequence s_wr_ctl;
    i_cfg_wr && i_cfg_addr[11:2] == OFF_LINK_CONTROL[11:2] && i_cfg_be[1:0] == 2'b11;
  endsequence
  property p_cap;
    s_rd_cap |=> o_cfg_rdata[31:18] == 14'h0001 && o_cfg_rdata[11:0] == 12'hc12;
  endproperty
  // latency fields lag a cycle, so only judged once inputs sat still
  property p_lat;
    s_rd_cap ##0 (!$past(i_rst) && $stable(lat_sel)) |=> o_cfg_rdata[17:12] == $past(lat_sel);
  endproperty
  property p_ctl;
    s_rd_ctl |=> o_cfg_rdata[15:0] == $past(ctl_view);
  endproperty
  property p_sts;
    s_rd_ctl |=> o_cfg_rdata[31:16] == {12'h101, $past(i_current_link_speed)};
  endproperty
  property p_wr;
    s_wr_ctl |=> o_cfg_wr_done && ctl_view == ($past(i_cfg_wdata[15:0]) & 16'h01cb);
  endproperty
  property p_hold;
    !i_cfg_wr |=> $stable(ctl_view);
  endproperty
  property p_dec;
    o_l0s_entry_enable == o_aspm_control[0] && o_l1_entry_enable == o_aspm_control[1];
  endproperty
  property p_rdv;
    i_cfg_rd |=> o_cfg_rd_valid;
  endproperty
  property p_wrd;
    i_cfg_wr |=> o_cfg_wr_done;
  endproperty
  a_cap: assert property (p_cap) else $error("capability constants wrong");
  a_lat: assert property (p_lat) else $error("exit latency wrong");
  a_ctl: assert property (p_ctl) else $error("control readback wrong");
  a_sts: assert property (p_sts) else $error("status word wrong");
  a_wr: assert property (p_wr) else $error("control write wrong");
  a_hold: assert property (p_hold) else $error("control changed unwritten");
  a_dec: assert property (p_dec) else $error("entry enables wrong");
  a_rdv: assert property (p_rdv) else $error("read not answered");
  a_wrd: assert property (p_wrd) else $error("write not answered");
endmodule
bind link_cap_ctrl_regs link_cap_ctrl_regs_asserts u_chk (.*);

// *** verif/link_cfg_host.sv ***
// host configuration software model on the config access port
`timescale 1ns/1ns
module link_cfg_host (
  input wire logic i_ref_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_rd_valid,
  input wire logic i_wr_done,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [11:0] o_addr = 12'h000,
  output logic [3:0] o_be = 4'h0,
  output logic [31:0] o_wdata = 32'h0000_0000
);
  // one access per call; released address and data show the inverse, byte enables keep their last value
  task automatic access(input logic w, input logic [11:0] a, input logic [3:0] b,
    input logic [31:0] d, output logic [31:0] q, output logic ack);
    @(posedge i_ref_clk);
    #1;
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_be = b;
    o_wdata = d;
    @(posedge i_ref_clk);
    #1;
    ack = w ? i_wr_done : i_rd_valid;
    q = i_rdata;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
endmodule

// *** verif/link_cap_ctrl_regs_tb.sv ***
// self-checking bench for the link register bank
`timescale 1ns/1ns
module link_cap_ctrl_regs_tb;
  import link_cap_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr, rd, rv, wd, e0, e1, cpm, es, ccc, read_completion_boundary;
  logic [11:0] addr;
  logic [3:0] be;
  logic [3:0] spd = 4'h2;
  logic [2:0] l1a = 3'h5;
  logic [2:0] l0a = 3'h6;
  logic [31:0] wdata, rdata;
  logic [1:0] aspm;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  // ****************
  // harness
  // ****************
  always #2 clk = ~clk;
  link_cap_ctrl_regs dut (.i_ref_clk(clk), .i_rst(rst), .i_cfg_wr(wr), .i_cfg_rd(rd),
    .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
    .o_cfg_rd_valid(rv), .o_cfg_wr_done(wd), .i_l1_exit_time_async(l1a),
    .i_l1_exit_time_shared_clk(3'h2), .i_l0s_exit_time_async(l0a),
    .i_l0s_exit_time_shared_clk(3'h1), .i_current_link_speed(spd),
    .o_aspm_control(aspm), .o_l0s_entry_enable(e0), .o_l1_entry_enable(e1),
    .o_clock_pm_enable(cpm), .o_extended_synch(es), .o_common_clock_select(ccc),
    .o_read_completion_boundary(read_completion_boundary));
  link_cfg_host host (.i_ref_clk(clk), .i_rdata(rdata), .i_rd_valid(rv), .i_wr_done(wd),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_be(be), .o_wdata(wdata));
  // hang guard, far above the roughly 70 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic final_report;
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr32(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    logic [31:0] q;
    logic k;
    host.access(1'b1, a, b, d, q, k);
    chk({31'h0, k}, 32'h1);
  endtask
  task automatic rd32(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic k;
    host.access(1'b0, a, 4'hf, 32'h0, q, k);
    chk({31'h0, k}, 32'h1);
    chk(q, exp);
  endtask
  // ****************
  // scenarios
  // ****************
  // capability word, then a write that must not stick
  task automatic t_cap(input logic [5:0] lat);
    rd32(OFF_LINK_CAPABILITIES, {13'h0, 1'b1, lat, 12'hc12});
    wr32(OFF_LINK_CAPABILITIES, 4'hf, 32'hffff_ffff);
    rd32(OFF_LINK_CAPABILITIES, {13'h0, 1'b1, lat, 12'hc12});
  endtask
  // all ones into control; only writable bits may land
  task automatic t_ctl;
    wr32(OFF_LINK_CONTROL, 4'hf, 32'hffff_ffff);
    chk({24'h0, cpm, es, ccc, read_completion_boundary, e1, e0, aspm}, 32'h0000_00ff);
    rd32(OFF_LINK_CONTROL, {12'h101, spd, 16'h01cb});
    t_cap({3'h2, 3'h1});
  endtask
  // every power mode, with live speed and the status alias address
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      #1;
      spd = 4'(m);
      wr32(OFF_LINK_CONTROL, 4'h3, {16'hffff, 14'h0, 2'(m)});
      chk({24'h0, cpm, es, ccc, read_completion_boundary, e1, e0, aspm}, {28'h0, 2'(m), 2'(m)});
      rd32(OFF_LINK_STATUS, {12'h101, 4'(m), 14'h0, 2'(m)});
    end
    rd32(12'h040, 32'h0000_0000);
  endtask
  // reset in mid-run clears the control word
  task automatic t_rst;
    wr32(OFF_LINK_CONTROL, 4'h3, 32'h0000_01cb);
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({24'h0, cpm, es, ccc, read_completion_boundary, e1, e0, aspm}, 32'h0000_0000);
    rd32(OFF_LINK_CONTROL, {12'h101, spd, 16'h0000});
    // new async latencies must reach the capability word
    l1a = 3'h3;
    l0a = 3'h4;
    t_cap({3'h3, 3'h4});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_cap({3'h5, 3'h6});
    t_ctl();
    t_modes();
    t_rst();
    final_report();
  end
endmodule
